// file: iosi_status_ind.sv
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module iosi_status_ind
  import iosi_pkg::*;
#(
  parameter int BLINK_CYC = BLINK_HALF_CYC,
  parameter int FLASH_CYC = ACT_FLASH_CYC
) (
  input wire logic sys_clk,
  input wire logic srst,
  // ports and router side
  input wire logic [NPORT-1:0] portEnable,
  input wire logic portReset,
  input wire iosi_port_s portIn,
  // unit health
  input wire logic [1:0] supplyOk,
  input wire logic fanFail,
  // rear switch bank, one bit per closed position
  input wire logic [SW_W-1:0] addrSwitch,
  // register port
  input wire iosi_bus_s bus,
  output logic [BD_W-1:0] rdData,
  output logic irq,
  // front panel and address
  output iosi_led_s leds,
  output logic [SYS_W+SW_W-1:0] fullAddr
);

  // ==========================================================
  // shared blink and per-port activity stretchers
  logic blink;
  logic [NPORT-1:0] actLit;

  iosi_blink_div #(
    .HALF_CYC(BLINK_CYC)
  ) u_div (
    .sys_clk(sys_clk),
    .srst(srst),
    .blink(blink)
  );

  genvar gp;
  generate
    for (gp = 0; gp < NPORT; gp++) begin : g_act
      iosi_act_flash #(
        .HOLD_CYC(FLASH_CYC)
      ) u_act (
        .sys_clk(sys_clk),
        .srst(srst),
        .traffic(portIn.traffic[gp] & portIn.linkUp[gp]),
        .lit(actLit[gp])
      );
    end
  endgenerate

  // ==========================================================
  // state
  typedef struct packed {
    logic lampsOn;
    logic [SYS_W-1:0] sysAddr;
    logic [NEV-1:0] intStat;
    logic [NEV-1:0] intMask;
    logic [NPORT-1:0] src;
    logic [NPORT-1:0] prevLink;
    logic prevPwr;
    logic prevFan;
    iosi_led_s led;
    logic [SYS_W+SW_W-1:0] addr;
    logic [BD_W-1:0] rd;
    logic irq;
  } iosi_st_s;

  iosi_st_s st_r;
  iosi_st_s st_nxt;

  logic pwrOk;
  logic wrCtrl;
  logic wrSys;
  logic wrStat;
  logic wrMask;

  assign pwrOk = &supplyOk;
  assign wrCtrl = bus.wr && (bus.addr == OFS_CTRL);
  assign wrSys = bus.wr && (bus.addr == OFS_SYSADDR);
  assign wrStat = bus.wr && (bus.addr == OFS_INTSTAT);
  assign wrMask = bus.wr && (bus.addr == OFS_INTMASK);

  // ==========================================================
  // next state
  always_comb begin
    logic [NEV-1:0] ev;
    logic [NEV-1:0] clr;
    iosi_led_s l;
    ev = '0;
    clr = '0;
    l = '0;
    st_nxt = st_r;

    // ------------------------------------------------------
    // register writes
    if (wrCtrl) begin
      st_nxt.lampsOn = bus.wdata[CTRL_LAMPS_ON];
    end
    if (wrSys) begin
      st_nxt.sysAddr = bus.wdata[SYS_W-1:0];
    end
    if (wrMask) begin
      st_nxt.intMask = bus.wdata[NEV-1:0];
    end
    if (wrStat) begin
      clr = bus.wdata[NEV-1:0];
    end

    // ------------------------------------------------------
    // audio/sync source: a one-hot request is taken as is; a
    // conflicting request keeps the port already in use (port 0 if none) so a
    // glitch on the router side cannot light both lamps
    unique case (portIn.srcReq)
      2'b01: st_nxt.src = 2'b01;
      2'b10: st_nxt.src = 2'b10;
      2'b11: begin
        if (st_r.src == 2'b00) begin
          st_nxt.src = 2'b01;
        end else begin
          st_nxt.src = st_r.src;
        end
      end
      2'b00: st_nxt.src = 2'b00;
    endcase

    // ------------------------------------------------------
    // events: falling link, falling power, rising fan fault
    st_nxt.prevLink = portIn.linkUp;
    st_nxt.prevPwr = pwrOk;
    st_nxt.prevFan = fanFail;
    ev[EV_LINK0] = st_r.prevLink[0] & ~portIn.linkUp[0];
    ev[EV_LINK1] = st_r.prevLink[1] & ~portIn.linkUp[1];
    ev[EV_PWR] = st_r.prevPwr & ~pwrOk;
    ev[EV_FAN] = ~st_r.prevFan & fanFail;
    // a new event beats a simultaneous write-one-to-clear
    st_nxt.intStat = (st_r.intStat & ~clr) | ev;
    st_nxt.irq = |(st_nxt.intStat & st_nxt.intMask);

    // ------------------------------------------------------
    // front panel lamps
    l.portEn = (&portEnable) & ~portReset;
    for (int p = 0; p < NPORT; p++) begin
      // heartbeat holds steady dark when the link is not valid
      l.heartbeat[p] = portIn.hbValid[p] & blink;
      l.ctrlLink[p] = portIn.ctrlValid[p];
      l.present[p] = portIn.linkUp[p];
      l.activity[p] = actLit[p];
    end
    l.source = st_nxt.src;
    l.powerGood = pwrOk;
    l.fanFault = fanFail & blink;
    // software blanking only darkens lamps, so the source pair
    // stays mutually exclusive either way
    if (st_nxt.lampsOn) begin
      st_nxt.led = l;
    end else begin
      st_nxt.led = '0;
    end

    // ------------------------------------------------------
    // unit address: switch bits carry their own binary weight
    st_nxt.addr = {st_nxt.sysAddr, addrSwitch};

    // ------------------------------------------------------
    // read data, valid only in the cycle after the strobe
    st_nxt.rd = '0;
    if (bus.rd) begin
      unique case (bus.addr)
        OFS_CTRL: begin
          st_nxt.rd[CTRL_LAMPS_ON] = st_r.lampsOn;
        end
        OFS_SYSADDR: begin
          st_nxt.rd[SYS_W-1:0] = st_r.sysAddr;
        end
        OFS_STATUS: begin
          st_nxt.rd[11:0] = {fanFail, pwrOk, st_r.src,
                             portIn.ctrlValid, portIn.hbValid,
                             portIn.linkUp, portEnable};
        end
        OFS_INTSTAT: begin
          st_nxt.rd[NEV-1:0] = st_r.intStat;
        end
        OFS_INTMASK: begin
          st_nxt.rd[NEV-1:0] = st_r.intMask;
        end
        OFS_FULLADDR: begin
          st_nxt.rd[SYS_W+SW_W-1:0] = st_r.addr;
        end
        default: begin
          st_nxt.rd = '0;
        end
      endcase
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_r <= '0;
      st_r.lampsOn <= CTRL_RST;
      st_r.sysAddr <= SYSADDR_RST;
      st_r.intMask <= INTMASK_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // outputs, all straight from state flops
  assign leds = st_r.led;
  assign fullAddr = st_r.addr;
  assign rdData = st_r.rd;
  assign irq = st_r.irq;

endmodule
`default_nettype wire

// file: iosi_pkg.sv
// Contract
// - port-enable lamp lit only while both ports enabled and not in reset.
// - per port, heartbeat lamp blinks about 2 Hz while link valid, else steady.
// - per port, control-link lamp lit while remote control path exists.
// - per port, source lamp lit while audio and sync come from that port.
// - never both source lamps lit; both dark is allowed.
// - power-good lamp lit while both supplies healthy, off on any failure.
// - cooling-fault lamp flashes on fan failure, dark otherwise.
// - per port, link-present lamp steady while physically connected.
// - per port, link-activity lamp flashes when traffic is seen.
// - unit address is switch bank binary value appended to system part.
package iosi_pkg;

  // ==========================================================
  // timing
  localparam int CLK_HZ = 25_000_000;
  localparam int BLINK_HZ = 2;
  localparam int BLINK_HALF_CYC = CLK_HZ / (2 * BLINK_HZ);
  localparam int ACT_FLASH_MS = 50;
  localparam int ACT_FLASH_CYC = (CLK_HZ / 1000) * ACT_FLASH_MS;

  // ==========================================================
  // widths
  localparam int NPORT = 2;
  localparam int SW_W = 8;
  localparam int SYS_W = 8;
  localparam int BA_W = 8;
  localparam int BD_W = 32;
  localparam int NEV = 4;

  // ==========================================================
  // register offsets
  localparam logic [BA_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [BA_W-1:0] OFS_SYSADDR = 8'h04;
  localparam logic [BA_W-1:0] OFS_STATUS = 8'h08;
  localparam logic [BA_W-1:0] OFS_INTSTAT = 8'h0C;
  localparam logic [BA_W-1:0] OFS_INTMASK = 8'h10;
  localparam logic [BA_W-1:0] OFS_FULLADDR = 8'h14;

  // ==========================================================
  // field positions and reset values
  localparam int CTRL_LAMPS_ON = 0;
  localparam int EV_LINK0 = 0;
  localparam int EV_LINK1 = 1;
  localparam int EV_PWR = 2;
  localparam int EV_FAN = 3;
  localparam logic CTRL_RST = 1'b1;
  localparam logic [SYS_W-1:0] SYSADDR_RST = 8'h00;
  localparam logic [NEV-1:0] INTMASK_RST = 4'h0;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [NPORT-1:0] linkUp;
    logic [NPORT-1:0] traffic;
    logic [NPORT-1:0] hbValid;
    logic [NPORT-1:0] ctrlValid;
    logic [NPORT-1:0] srcReq;
  } iosi_port_s;

  typedef struct packed {
    logic portEn;
    logic [NPORT-1:0] heartbeat;
    logic [NPORT-1:0] ctrlLink;
    logic [NPORT-1:0] source;
    logic powerGood;
    logic fanFault;
    logic [NPORT-1:0] present;
    logic [NPORT-1:0] activity;
  } iosi_led_s;

  typedef struct packed {
    logic [BA_W-1:0] addr;
    logic [BD_W-1:0] wdata;
    logic wr;
    logic rd;
  } iosi_bus_s;

endpackage

// file: iosi_blink_div.sv
`timescale 1ns/100ps
`default_nettype none
module iosi_blink_div
  import iosi_pkg::*;
#(
  parameter int HALF_CYC = BLINK_HALF_CYC
) (
  input wire logic sys_clk,
  input wire logic srst,
  output logic blink
);

  localparam int CW = $clog2(HALF_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(HALF_CYC - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic wave;
  } iosi_div_s;

  iosi_div_s st_r;
  iosi_div_s st_nxt;

  // ==========================================================
  // free-running square wave, never gated so all lamps share phase
  always_comb begin
    st_nxt = st_r;
    if (st_r.cnt == LAST) begin
      st_nxt.cnt = '0;
      st_nxt.wave = ~st_r.wave;
    end else begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign blink = st_r.wave;

endmodule
`default_nettype wire

// file: iosi_act_flash.sv
`timescale 1ns/100ps
`default_nettype none
module iosi_act_flash
  import iosi_pkg::*;
#(
  parameter int HOLD_CYC = ACT_FLASH_CYC
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic traffic,
  output logic lit
);

  localparam int CW = $clog2(HOLD_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(HOLD_CYC - 1);

  typedef enum logic [1:0] {IDLE, ON, GAP} iosi_fl_e;

  typedef struct packed {
    iosi_fl_e ph;
    logic [CW-1:0] cnt;
  } iosi_fl_s;

  iosi_fl_s st_r;
  iosi_fl_s st_nxt;

  // ==========================================================
  // on for one hold time, then a forced dark gap so that steady
  // traffic still shows as flashing instead of a solid lamp
  always_comb begin
    st_nxt = st_r;
    unique case (st_r.ph)
      IDLE: begin
        if (traffic) begin
          st_nxt.ph = ON;
          st_nxt.cnt = '0;
        end
      end
      ON: begin
        if (st_r.cnt == LAST) begin
          st_nxt.ph = GAP;
          st_nxt.cnt = '0;
        end else begin
          st_nxt.cnt = st_r.cnt + 1'b1;
        end
      end
      GAP: begin
        if (st_r.cnt == LAST) begin
          st_nxt.ph = IDLE;
          st_nxt.cnt = '0;
        end else begin
          st_nxt.cnt = st_r.cnt + 1'b1;
        end
      end
      default: begin
        st_nxt.ph = IDLE;
        st_nxt.cnt = '0;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_r <= '{ph: IDLE, cnt: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign lit = (st_r.ph == ON);

endmodule
`default_nettype wire

// file: iosi_router_model.sv
`timescale 1ns/100ps
`default_nettype none
module iosi_router_model
  import iosi_pkg::*;
(
  input wire logic [NPORT-1:0] up,
  input wire logic [NPORT-1:0] srcSel,
  input wire logic burst,
  output iosi_port_s portIn
);
  // ==========
  // router side
  // a missing router shows nothing at all on its port
  assign portIn.linkUp = up;
  assign portIn.hbValid = up;
  assign portIn.ctrlValid = up;
  assign portIn.traffic = up & {NPORT{burst}};
  // both selected only when a test asks for a conflict
  assign portIn.srcReq = up & srcSel;
endmodule
`default_nettype wire

// file: iosi_status_ind_chk.sv
`timescale 1ns/100ps
`default_nettype none
module iosi_status_ind_chk
  import iosi_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [NPORT-1:0] portEnable,
  input wire logic portReset,
  input wire iosi_port_s portIn,
  input wire logic [1:0] supplyOk,
  input wire logic fanFail,
  input wire logic [SW_W-1:0] addrSwitch,
  input wire iosi_bus_s bus,
  input wire logic [BD_W-1:0] rdData,
  input wire logic irq,
  input wire iosi_led_s leds,
  input wire logic [SYS_W+SW_W-1:0] fullAddr
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // ==========
  // blanking as seen on the register port, so that the level
  // checks stand aside while software holds the panel dark
  logic lampsOn_r;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      lampsOn_r <= CTRL_RST;
    end else if (bus.wr && bus.addr == OFS_CTRL) begin
      lampsOn_r <= bus.wdata[CTRL_LAMPS_ON];
    end
  end
  // ==========
  // lamps; blink windows assume the short blink count of the bench
  sequence hbHeld;
    portIn.hbValid[0] [*8];
  endsequence
  chk_port_en: assert property (
    !$past(srst) && lampsOn_r |->
      leds.portEn == (&$past(portEnable) && !$past(portReset)))
    else $error("port enable lamp wrong");
  chk_hb_blink: assert property (
    hbHeld |-> ##[0:5]
      (leds.heartbeat[0] || !portIn.hbValid[0] || !lampsOn_r))
    else $error("heartbeat not blinking");
  chk_hb_gap: assert property (
    hbHeld |-> ##[0:5] !leds.heartbeat[0])
    else $error("heartbeat stuck lit");
  chk_ctrl_link: assert property (
    !$past(srst) && lampsOn_r |-> leds.ctrlLink == $past(portIn.ctrlValid))
    else $error("control link lamp wrong");
  chk_src_one: assert property (
    !$past(srst) && lampsOn_r && $past(portIn.srcReq) == 2'h1 |->
      leds.source == 2'h1)
    else $error("source lamp wrong");
  chk_src_excl: assert property (
    !(leds.source[0] && leds.source[1]))
    else $error("both source lamps lit");
  chk_lamps_blank: assert property (
    !lampsOn_r |-> leds == '0)
    else $error("lamps lit while blanked");
  chk_power_good: assert property (
    !$past(srst) && lampsOn_r |-> leds.powerGood == &$past(supplyOk))
    else $error("power good lamp wrong");
  chk_fan_dark: assert property (
    !$past(srst) && !$past(fanFail) |-> !leds.fanFault)
    else $error("fan lamp lit without fault");
  chk_link_present: assert property (
    !$past(srst) && lampsOn_r |-> leds.present == $past(portIn.linkUp))
    else $error("link present lamp wrong");
  chk_act_cause: assert property (
    $rose(leds.activity[0]) |-> $past(portIn.traffic[0], 2))
    else $error("activity lamp without traffic");
  chk_addr_low: assert property (
    !$past(srst) |-> fullAddr[SW_W-1:0] == $past(addrSwitch))
    else $error("unit address wrong");
endmodule
bind iosi_status_ind iosi_status_ind_chk u_chk (.sys_clk, .srst,
  .portEnable, .portReset, .portIn, .supplyOk, .fanFail, .addrSwitch,
  .bus, .rdData, .irq, .leds, .fullAddr);
`default_nettype wire

// file: iosi_status_ind_tb.sv
`timescale 1ns/100ps
`default_nettype none
module iosi_status_ind_tb
  import iosi_pkg::*;
;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [NPORT-1:0] portEnable = 2'h0;
  logic [NPORT-1:0] up = 2'h0;
  logic [NPORT-1:0] srcSel = 2'h0;
  logic portReset = 1'b0;
  logic burst = 1'b0;
  logic fanFail = 1'b0;
  logic [1:0] supplyOk = 2'h3;
  logic [SW_W-1:0] addrSwitch = 8'hA5;
  iosi_bus_s bus = '0;
  iosi_port_s portIn;
  logic [BD_W-1:0] rdData;
  logic irq;
  iosi_led_s leds;
  logic [SYS_W+SW_W-1:0] fullAddr;
  logic [1:0] sSel [3] = '{2'h3, 2'h2, 2'h0};
  logic [1:0] sExp [3] = '{2'h1, 2'h2, 2'h0};
  int miscompares = 0;
  int totalChecks = 0;
  int hi;

  initial begin
    forever #20 sys_clk = ~sys_clk;
  end

  // short counts keep blink and flash observable
  iosi_status_ind #(.BLINK_CYC(4), .FLASH_CYC(3)) uut (.sys_clk, .srst,
    .portEnable, .portReset, .portIn, .supplyOk, .fanFail, .addrSwitch,
    .bus, .rdData, .irq, .leds, .fullAddr);
  iosi_router_model router (.up, .srcSel, .burst, .portIn);

  // ==========
  // helpers
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    totalChecks++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task busWr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge sys_clk);
    bus.wr <= 1'b0;
  endtask
  task busRd(input logic [7:0] a, input logic [31:0] e, input string n);
    @(posedge sys_clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    @(negedge sys_clk);
    chk(n, rdData, e);
  endtask
  task count16(input int sel);
    hi = 0;
    repeat (16) begin
      @(negedge sys_clk);
      if (sel == 0) begin
        hi += leds.heartbeat[0] + 16 * leds.heartbeat[1];
      end else begin
        hi += leds.fanFault;
      end
    end
  endtask
  task give_verdict;
    if (miscompares == 0 && totalChecks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (4000) @(posedge sys_clk);
    miscompares++;
    give_verdict;
  end

  // ==========
  // tests
  initial begin
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    busRd(OFS_CTRL, 32'h1, "ctrl");
    busRd(OFS_INTMASK, 32'h0, "intMask");
    busRd(8'h18, 32'h0, "unmapped");
    @(posedge sys_clk);
    portEnable <= 2'h3;
    up <= 2'h3;
    srcSel <= 2'h1;
    cyc(2);
    chk("portEn", leds.portEn, 1'b1);
    chk("present", leds.present, 2'h3);
    chk("ctrlLink", leds.ctrlLink, 2'h3);
    chk("powerGood", leds.powerGood, 1'b1);
    busRd(OFS_STATUS, 32'h5FF, "status");
    busWr(OFS_CTRL, 32'h0);
    cyc(1);
    chk("ledsOff", leds, 32'h0);
    busRd(OFS_CTRL, 32'h0, "ctrl");
    busWr(OFS_CTRL, 32'h1);
    @(posedge sys_clk);
    portReset <= 1'b1;
    cyc(2);
    chk("portEn", leds.portEn, 1'b0);
    @(posedge sys_clk);
    portReset <= 1'b0;
    portEnable <= 2'h1;
    cyc(2);
    chk("portEn", leds.portEn, 1'b0);
    @(posedge sys_clk);
    portEnable <= 2'h3;
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk);
      srcSel <= sSel[i];
      cyc(2);
      chk("source", leds.source, sExp[i]);
    end
    @(posedge sys_clk);
    srcSel <= 2'h1;
    busWr(OFS_SYSADDR, 32'h3C);
    busRd(OFS_FULLADDR, 32'h3CA5, "fullAddr");
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk);
      addrSwitch <= 8'h01 << i;
      cyc(2);
      chk("fullAddr", fullAddr, {8'h3C, 8'h01 << i});
    end
    count16(0);
    chk("heartbeat", hi, 32'h88);
    @(posedge sys_clk);
    fanFail <= 1'b1;
    cyc(1);
    count16(1);
    chk("fanFault", hi, 8);
    @(posedge sys_clk);
    fanFail <= 1'b0;
    burst <= 1'b1;
    @(posedge sys_clk);
    burst <= 1'b0;
    hi = 0;
    repeat (12) begin
      @(negedge sys_clk);
      hi += leds.activity[0] + 16 * leds.activity[1];
    end
    chk("activity", hi, 32'h33);
    busWr(OFS_INTSTAT, 32'hF);
    busWr(OFS_INTMASK, 32'h4);
    @(posedge sys_clk);
    supplyOk <= 2'h1;
    cyc(3);
    chk("powerGood", leds.powerGood, 1'b0);
    chk("irq", irq, 1'b1);
    busRd(OFS_INTSTAT, 32'h4, "intStat");
    busWr(OFS_INTSTAT, 32'h4);
    cyc(1);
    chk("irq", irq, 1'b0);
    busWr(OFS_INTMASK, 32'h0);
    supplyOk <= 2'h3;
    @(posedge sys_clk);
    supplyOk <= 2'h2;
    cyc(3);
    chk("irq", irq, 1'b0);
    busRd(OFS_INTSTAT, 32'h4, "intStat");
    busWr(8'h1C, 32'hFF);
    busRd(OFS_SYSADDR, 32'h3C, "sysAddr");
    @(posedge sys_clk);
    up <= 2'h0;
    cyc(2);
    chk("present", leds.present, 2'h0);
    count16(0);
    chk("heartbeat", hi, 0);
    give_verdict;
  end
endmodule
`default_nettype wire
